// >>> pkg/adc_regs_pkg.sv
package adc_regs_pkg;
    // register byte addresses
    localparam logic [15:0] ADDR_RES0_LO = 16'hF2D0;
    localparam logic [15:0] ADDR_RES0_HI = 16'hF2D1;
    localparam logic [15:0] ADDR_RES1_LO = 16'hF2D2;
    localparam logic [15:0] ADDR_RES1_HI = 16'hF2D3;
    localparam logic [15:0] ADDR_CTL_A = 16'hF2F0;
    localparam logic [15:0] ADDR_CTL_B = 16'hF2F1;
    localparam logic [15:0] ADDR_CH_SEL = 16'hF2F2;
    localparam logic [15:0] ADDR_AMP_OFFS = 16'hF2F4;
    localparam logic [15:0] ADDR_AMP_GAIN = 16'hF2F5;
    localparam logic [15:0] ADDR_AMP_CTL = 16'hF2F6;
    // interrupt registers
    localparam logic [15:0] ADDR_IRQ_STAT = 16'hF2F8;
    localparam logic [15:0] ADDR_IRQ_EN = 16'hF2F9;
    localparam logic [15:0] ADDR_IRQ_CLR = 16'hF2FA;
    // values after reset
    localparam logic [7:0] RST_CTL_A = 8'h02;
    localparam logic [7:0] RST_CTL_B = 8'h00;
    localparam logic [7:0] RST_CH_SEL = 8'h00;
    localparam logic [7:0] RST_AMP_OFFS = 8'h03;
    localparam logic [7:0] RST_AMP_GAIN = 8'h00;
    localparam logic [7:0] RST_AMP_CTL = 8'h00;
    // field positions
    localparam int LOOP_BIT = 0;
    localparam int CLK_RANGE_BIT = 1;
    localparam int RUN_BIT = 0;
    localparam int SEL_CH0_BIT = 0;
    localparam int SEL_CH1_BIT = 1;
    localparam int AMP_SHORT_BIT = 2;
    // interrupt status bits
    localparam int EV_CH0 = 0;
    localparam int EV_CH1 = 1;
    localparam int EV_STOP = 2;
    localparam int EV_W = 3;
    // result width
    localparam int RES_W = 12;
    // sequencer states
    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_BUSY = 1'b1
    } seq_state_t;
endpackage : adc_regs_pkg

// >>> rtl/sar_adc_register_interface.sv
// Decided for this implementation: the plain strobed port.
`timescale 1ns/100ps
module sar_adc_register_interface (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // register port
    input wire logic [15:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic bus_word,
    output logic [15:0] bus_rdata,
    // converter core
    output logic conv_start,
    output logic conv_chan,
    output logic conv_clk_range,
    input wire logic conv_done,
    input wire logic [adc_regs_pkg::RES_W-1:0] conv_data,
    // amplifier settings
    output logic [4:0] amp_offset,
    output logic [3:0] amp_gain,
    output logic [1:0] amp_mode,
    output logic amp_short,
    // events
    output logic conv_end,
    output logic irq
);
    import adc_regs_pkg::*;

    // whole state of the block
    typedef struct packed {
        seq_state_t st;              // sequencer state
        logic chan;                  // channel in conversion
        logic [7:0] ctl_a;           // loop and clock range
        logic [7:0] ctl_b;           // run control
        logic [7:0] ch_sel;          // channel select
        logic [7:0] offs;            // second stage offset
        logic [7:0] gain;            // second stage gain
        logic [7:0] ampc;            // amplifier input control
        logic [RES_W-1:0] res0;      // channel 0 result
        logic [RES_W-1:0] res1;      // channel 1 result
        logic [EV_W-1:0] stat;       // sticky events
        logic [EV_W-1:0] ien;        // event enables
        logic [15:0] rdata;          // read data
        logic start;                 // core start pulse
        logic cend;                  // conversion end pulse
    } adc_state_t;

    adc_state_t st_r;   // registered state
    adc_state_t st_nxt; // next state

    // shorthand views of control bits
    logic run;
    logic loop;
    logic sel0;
    logic sel1;
    logic last;
    logic done_ok;
    assign run = st_r.ctl_b[RUN_BIT];
    assign loop = st_r.ctl_a[LOOP_BIT];
    assign sel0 = st_r.ch_sel[SEL_CH0_BIT];
    assign sel1 = st_r.ch_sel[SEL_CH1_BIT];
    // no higher channel left in this pass
    assign last = st_r.chan | ~sel1;
    // completion accepted only while converting
    assign done_ok = (st_r.st == ST_BUSY) & run & conv_done;

    // byte view of one register address
    // a word read calls this twice on the same snapshot
    function automatic logic [7:0] rd_byte(input adc_state_t s, input logic [15:0] a);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            ADDR_RES0_LO: v = {s.res0[3:0], 4'h0};
            ADDR_RES0_HI: v = s.res0[11:4];
            ADDR_RES1_LO: v = {s.res1[3:0], 4'h0};
            ADDR_RES1_HI: v = s.res1[11:4];
            ADDR_CTL_A: v = s.ctl_a;
            ADDR_CTL_B: v = s.ctl_b;
            ADDR_CH_SEL: v = s.ch_sel;
            ADDR_AMP_OFFS: v = s.offs;
            ADDR_AMP_GAIN: v = s.gain;
            ADDR_AMP_CTL: v = s.ampc;
            ADDR_IRQ_STAT: v = {5'h00, s.stat};
            ADDR_IRQ_EN: v = {5'h00, s.ien};
            default: v = 8'h00;   // unmapped reads zero
        endcase
        return v;
    endfunction : rd_byte

    // next-state logic
    always_comb begin
        logic [EV_W-1:0] ev;
        logic [EV_W-1:0] clr;
        ev = '0;
        clr = '0;
        st_nxt = st_r;
        st_nxt.start = 1'b0;
        st_nxt.cend = 1'b0;
        // sequencer
        unique case (st_r.st)
            ST_IDLE: begin
                // start lowest selected channel; none selected just waits
                if (run && (sel0 || sel1)) begin
                    st_nxt.st = ST_BUSY;
                    st_nxt.chan = ~sel0;
                    st_nxt.start = 1'b1;
                end
            end
            ST_BUSY: begin
                if (!run) begin
                    // software stop abandons the pass
                    st_nxt.st = ST_IDLE;
                end else if (conv_done) begin
                    // store result only on completion
                    if (st_r.chan) begin
                        st_nxt.res1 = conv_data;
                        ev[EV_CH1] = 1'b1;
                    end else begin
                        st_nxt.res0 = conv_data;
                        ev[EV_CH0] = 1'b1;
                    end
                    st_nxt.cend = 1'b1;
                    if (!last) begin
                        // channel 1 follows channel 0
                        st_nxt.chan = 1'b1;
                        st_nxt.start = 1'b1;
                    end else if (loop) begin
                        // new pass from first channel
                        st_nxt.chan = ~sel0;
                        st_nxt.start = sel0 | sel1;
                        st_nxt.st = (sel0 | sel1) ? ST_BUSY : ST_IDLE;
                    end else begin
                        // single pass done: drop run
                        st_nxt.ctl_b[RUN_BIT] = 1'b0;
                        st_nxt.st = ST_IDLE;
                        ev[EV_STOP] = 1'b1;
                    end
                end
            end
        endcase
        // register writes; a write to run wins over auto clear
        // result and status addresses fall to the default and are dropped
        if (bus_wr) begin
            unique case (bus_addr)
                ADDR_CTL_A: st_nxt.ctl_a = bus_wdata;
                ADDR_CTL_B: st_nxt.ctl_b = bus_wdata;
                ADDR_CH_SEL: st_nxt.ch_sel = bus_wdata;
                ADDR_AMP_OFFS: st_nxt.offs = bus_wdata;
                ADDR_AMP_GAIN: st_nxt.gain = bus_wdata;
                ADDR_AMP_CTL: st_nxt.ampc = bus_wdata;
                ADDR_IRQ_EN: st_nxt.ien = bus_wdata[EV_W-1:0];
                ADDR_IRQ_CLR: clr = bus_wdata[EV_W-1:0];
                default: ;   // read-only or unmapped: ignored
            endcase
        end
        // sticky events, set beats clear
        st_nxt.stat = (st_r.stat & ~clr) | ev;
        // read data valid one cycle after strobe only
        st_nxt.rdata = 16'h0000;
        if (bus_rd) begin
            st_nxt.rdata[7:0] = rd_byte(st_r, bus_addr);
            // upper byte from same snapshot
            if (bus_word) begin
                st_nxt.rdata[15:8] = rd_byte(st_r, bus_addr + 16'h0001);
            end
        end
    end

    // state register
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st_r <= '0;
            st_r.st <= ST_IDLE;
            st_r.ctl_a <= RST_CTL_A;
            st_r.ctl_b <= RST_CTL_B;
            st_r.ch_sel <= RST_CH_SEL;
            st_r.offs <= RST_AMP_OFFS;
            st_r.gain <= RST_AMP_GAIN;
            st_r.ampc <= RST_AMP_CTL;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs from flops
    assign bus_rdata = st_r.rdata;
    assign conv_start = st_r.start;
    assign conv_chan = st_r.chan;
    assign conv_clk_range = st_r.ctl_a[CLK_RANGE_BIT];
    assign amp_offset = st_r.offs[4:0];
    assign amp_gain = st_r.gain[3:0];
    assign amp_mode = st_r.ampc[1:0];
    assign amp_short = st_r.ampc[AMP_SHORT_BIT];
    assign conv_end = st_r.cend;
    // level interrupt from enabled sticky bits
    assign irq = |(st_r.stat & st_r.ien);

    // checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);
    // every check below pauses while reset is held

    // start is a lone pulse
    a_start_single_pulse: assert property (
        conv_start |=> !conv_start
    ) else $error("start pulse longer than one cycle");

    // ch0 completion lands in result and event
    a_res0_capture: assert property (
        (done_ok && !st_r.chan) |=> (st_r.res0 == $past(conv_data)) && conv_end
    ) else $error("ch0 result not captured");

    // results hold without completion
    a_res_hold: assert property (
        !done_ok |=> $stable(st_r.res0) && $stable(st_r.res1)
    ) else $error("result changed without completion");

    // ch0 low byte layout
    a_low_nibble_zero: assert property (
        (bus_rd && !bus_word && bus_addr == ADDR_RES0_LO)
        |=> bus_rdata == {8'h00, $past(st_r.res0[3:0]), 4'h0}
    ) else $error("ch0 low byte wrong");

    // ch1 low byte layout
    a_ch1_low_layout: assert property (
        (bus_rd && !bus_word && bus_addr == ADDR_RES1_LO)
        |=> bus_rdata == {8'h00, $past(st_r.res1[3:0]), 4'h0}
    ) else $error("ch1 low byte wrong");

    // coherent word read
    a_word_coherent: assert property (
        (bus_rd && bus_word && bus_addr == ADDR_RES1_LO)
        |=> bus_rdata == {$past(st_r.res1), 4'h0}
    ) else $error("word read not coherent");

    // single mode drops run after last channel
    a_single_stop: assert property (
        (done_ok && last && !loop && !bus_wr) |=> !run ##1 !conv_start
    ) else $error("run not cleared after pass");

    // ch1 follows ch0 in one pass
    a_ch_order: assert property (
        (done_ok && !st_r.chan && sel1) |=> conv_start && conv_chan
    ) else $error("channel 1 not started after channel 0");

    // loop mode restarts at first channel
    a_loop_restart: assert property (
        (done_ok && last && loop && sel0) |=> conv_start && !conv_chan && run
    ) else $error("loop pass not restarted");

    // short control follows register
    a_short_follow: assert property (
        (bus_wr && bus_addr == ADDR_AMP_CTL) |=> amp_short == $past(bus_wdata[AMP_SHORT_BIT])
    ) else $error("short control not applied");

    // gain setting reaches the second stage
    a_gain_follow: assert property (
        (bus_wr && bus_addr == ADDR_AMP_GAIN) |=> amp_gain == $past(bus_wdata[3:0])
    ) else $error("gain setting not applied");

    // offset setting reaches the second stage
    a_offs_follow: assert property (
        (bus_wr && bus_addr == ADDR_AMP_OFFS) |=> amp_offset == $past(bus_wdata[4:0])
    ) else $error("offset setting not applied");

    // clock range bit reaches the core
    a_range_follow: assert property (
        (bus_wr && bus_addr == ADDR_CTL_A) |=> conv_clk_range == $past(bus_wdata[CLK_RANGE_BIT])
    ) else $error("clock range not applied");

    // ch1 completion lands in its result and event
    a_res1_capture: assert property (
        (done_ok && st_r.chan) |=> (st_r.res1 == $past(conv_data)) && conv_end
    ) else $error("ch1 result not captured");

    // ch0 high byte layout
    a_ch0_high_layout: assert property (
        (bus_rd && !bus_word && bus_addr == ADDR_RES0_HI)
        |=> bus_rdata == {8'h00, $past(st_r.res0[11:4])}
    ) else $error("ch0 high byte wrong");

    // ch1 high byte layout
    a_ch1_high_layout: assert property (
        (bus_rd && !bus_word && bus_addr == ADDR_RES1_HI)
        |=> bus_rdata == {8'h00, $past(st_r.res1[11:4])}
    ) else $error("ch1 high byte wrong");

    // ch0 word read from one snapshot
    a_word_ch0: assert property (
        (bus_rd && bus_word && bus_addr == ADDR_RES0_LO)
        |=> bus_rdata == {$past(st_r.res0), 4'h0}
    ) else $error("ch0 word read not coherent");

    // read data stands only after a read strobe
    a_rdata_idle: assert property (
        !bus_rd |=> bus_rdata == 16'h0000
    ) else $error("read data outside read cycle");

    // no end pulse without an accepted completion
    a_end_only_done: assert property (
        !done_ok |=> !conv_end
    ) else $error("conversion end without completion");

    // ch0 end event is sticky, set beats clear
    a_ch0_event: assert property (
        (done_ok && !st_r.chan) |=> st_r.stat[EV_CH0]
    ) else $error("ch0 end event lost");

    // ch1 end event is sticky, set beats clear
    a_ch1_event: assert property (
        (done_ok && st_r.chan) |=> st_r.stat[EV_CH1]
    ) else $error("ch1 end event lost");

    // clear status means a quiet interrupt line
    a_irq_quiet: assert property (
        (st_r.stat == '0) |-> !irq
    ) else $error("interrupt without status");

    // stopped converter starts nothing
    a_stop_no_start: assert property (
        !run |=> !conv_start
    ) else $error("start while run is low");

    // no channel selected: nothing starts and run stays
    a_no_chan_wait: assert property (
        (st_r.st == ST_IDLE && run && !sel0 && !sel1 && !bus_wr) |=> !conv_start && run
    ) else $error("run without channel misbehaved");

    // a fresh run begins at the lowest selected channel
    a_first_channel: assert property (
        (st_r.st == ST_IDLE && $rose(run) && (sel0 || sel1))
        |=> conv_start && (conv_chan == !$past(sel0))
    ) else $error("pass began on wrong channel");

    // software stop drops the sequencer to idle
    a_abort_idle: assert property (
        (st_r.st == ST_BUSY && !run) |=> st_r.st == ST_IDLE
    ) else $error("abort did not reach idle");

    // a start pulse always belongs to a busy sequencer
    a_start_busy: assert property (
        conv_start |-> st_r.st == ST_BUSY
    ) else $error("start pulse while idle");

    // loop mode keeps run set across passes
    a_loop_keeps_run: assert property (
        (done_ok && loop && !bus_wr) |=> run
    ) else $error("run dropped in loop mode");

    // single pass end raises the stop event
    a_single_event: assert property (
        (done_ok && last && !loop) |=> st_r.stat[EV_STOP]
    ) else $error("single pass stop not flagged");

endmodule : sar_adc_register_interface

// >>> test/sar_adc_register_interface_tb_top.sv
`timescale 1ns/100ps
module sar_adc_register_interface_tb_top;
    import adc_regs_pkg::*;
    // clock, reset, register port and core stimulus
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic [15:0] bus_addr = 16'h0000;
    logic [7:0] bus_wdata = 8'h00;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic bus_word = 1'b0;
    logic conv_done = 1'b0;
    logic [11:0] conv_data = 12'h000;
    // design outputs
    logic [15:0] bus_rdata;
    logic conv_start, conv_chan, conv_clk_range, amp_short, conv_end, irq;
    logic [4:0] amp_offset;
    logic [3:0] amp_gain;
    logic [1:0] amp_mode;
    // counters
    int fail_count = 0;
    int samples_checked = 0;
    // reset table, one entry per result, control and amplifier register
    logic [15:0] rst_addr [10] = '{ADDR_RES0_LO, ADDR_RES0_HI, ADDR_RES1_LO, ADDR_RES1_HI, ADDR_CTL_A,
        ADDR_CTL_B, ADDR_CH_SEL, ADDR_AMP_OFFS, ADDR_AMP_GAIN, ADDR_AMP_CTL};
    logic [7:0] rst_val [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00};

    sar_adc_register_interface dut_u (.ref_clk(ref_clk), .srst(srst), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_word(bus_word),
        .bus_rdata(bus_rdata), .conv_start(conv_start), .conv_chan(conv_chan),
        .conv_clk_range(conv_clk_range), .conv_done(conv_done), .conv_data(conv_data),
        .amp_offset(amp_offset), .amp_gain(amp_gain), .amp_mode(amp_mode), .amp_short(amp_short),
        .conv_end(conv_end), .irq(irq));

    // 50 MHz clock
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end

    // compare and count
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // one-cycle write strobe
    task automatic wr(input logic [15:0] addr, input logic [7:0] data);
        @(posedge ref_clk);
        bus_wr <= 1'b1;
        bus_addr <= addr;
        bus_wdata <= data;
        @(posedge ref_clk);
        bus_wr <= 1'b0;
        #1;
    endtask : wr

    // one-cycle read strobe, data checked in the following cycle
    task automatic rd(input logic [15:0] addr, input logic word, input logic [15:0] exp, input string what);
        @(posedge ref_clk);
        bus_rd <= 1'b1;
        bus_addr <= addr;
        bus_word <= word;
        @(posedge ref_clk);
        bus_rd <= 1'b0;
        bus_word <= 1'b0;
        #1 chk(what, bus_rdata, exp);
    endtask : rd

    // act as the converter core for one conversion
    task automatic serve(input logic chan, input logic [11:0] data);
        int n;
        n = 0;
        while (conv_start !== 1'b1 && n < 50) begin
            @(posedge ref_clk);
            #1 n++;
        end
        chk("conversion start", {15'h0, conv_start}, 16'h0001);
        chk("converted channel", {15'h0, conv_chan}, {15'h0, chan});
        repeat (3) @(posedge ref_clk);
        conv_done <= 1'b1;
        conv_data <= data;
        @(posedge ref_clk);
        conv_done <= 1'b0;
        #1 chk("conversion end", {15'h0, conv_end}, 16'h0001);
    endtask : serve

    // no new conversion may begin for n cycles
    task automatic quiet(input int n);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            @(posedge ref_clk);
            #1 if (conv_start !== 1'b0) seen = 1'b1;
        end
        chk("idle sequencer", {15'h0, seen}, 16'h0000);
    endtask : quiet

    // verdict
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop

    // watchdog, far beyond the expected run length
    initial begin
        repeat (5000) @(posedge ref_clk);
        fail_count++;
        report_and_stop();
    end

    // main sequence
    initial begin
        repeat (12) @(posedge ref_clk);
        srst <= 1'b0;
        // reset values of the result, control and amplifier registers and the settings outputs
        for (int i = 0; i < 10; i++) begin
            rd(rst_addr[i], 1'b0, {8'h00, rst_val[i]}, "reset value");
        end
        chk("settings after reset", {3'h0, conv_clk_range, amp_offset, amp_gain, amp_mode, amp_short},
            {3'h0, 1'b1, 5'h03, 4'h0, 2'h0, 1'b0});
        rd(16'hF2E0, 1'b0, 16'h0000, "unmapped read");
        // amplifier settings and a refused write to a result register
        wr(ADDR_AMP_OFFS, 8'h1F);
        wr(ADDR_AMP_GAIN, 8'hA5);
        wr(ADDR_AMP_CTL, 8'h07);
        wr(ADDR_RES0_HI, 8'hFF);
        rd(ADDR_AMP_GAIN, 1'b0, 16'h00A5, "gain register");
        chk("amplifier outputs", {3'h0, conv_clk_range, amp_offset, amp_gain, amp_mode, amp_short},
            {3'h0, 1'b1, 5'h1F, 4'h5, 2'h3, 1'b1});
        rd(ADDR_RES0_HI, 1'b0, 16'h0000, "read-only result");
        // single pass over both channels, events enabled
        wr(ADDR_IRQ_EN, 8'h07);
        wr(ADDR_CH_SEL, 8'h03);
        wr(ADDR_CTL_B, 8'h01);
        serve(1'b0, 12'hABC);
        serve(1'b1, 12'h5A3);
        rd(ADDR_RES0_LO, 1'b1, 16'hABC0, "channel 0 word");
        rd(ADDR_RES0_HI, 1'b0, 16'h00AB, "channel 0 high");
        rd(ADDR_RES1_LO, 1'b0, 16'h0030, "channel 1 low");
        rd(ADDR_RES1_HI, 1'b0, 16'h005A, "channel 1 high");
        rd(ADDR_CTL_B, 1'b0, 16'h0000, "run after pass");
        rd(ADDR_IRQ_STAT, 1'b0, 16'h0007, "event status");
        chk("interrupt raised", {15'h0, irq}, 16'h0001);
        wr(ADDR_IRQ_CLR, 8'h07);
        chk("interrupt cleared", {15'h0, irq}, 16'h0000);
        // loop mode on both channels, events masked, then abort
        wr(ADDR_IRQ_EN, 8'h00);
        wr(ADDR_CTL_A, 8'h03);
        wr(ADDR_CH_SEL, 8'h03);
        wr(ADDR_CTL_B, 8'h01);
        serve(1'b0, 12'h123);
        serve(1'b1, 12'h456);
        serve(1'b0, 12'h789);
        rd(ADDR_CTL_B, 1'b0, 16'h0001, "run held in loop");
        wr(ADDR_CTL_B, 8'h00);
        @(posedge ref_clk);
        conv_done <= 1'b1;
        conv_data <= 12'hFFF;
        @(posedge ref_clk);
        conv_done <= 1'b0;
        rd(ADDR_RES1_LO, 1'b1, 16'h4560, "result after abort");
        rd(ADDR_RES0_LO, 1'b1, 16'h7890, "ch0 after abort");
        chk("masked interrupt", {15'h0, irq}, 16'h0000);
        rd(ADDR_IRQ_STAT, 1'b0, 16'h0003, "masked status");
        // single mode converts channel 0 once only
        wr(ADDR_CTL_A, 8'h02);
        wr(ADDR_CH_SEL, 8'h01);
        wr(ADDR_CTL_B, 8'h01);
        serve(1'b0, 12'h00F);
        quiet(20);
        rd(ADDR_RES0_LO, 1'b1, 16'h00F0, "single result");
        // run with no channel selected does nothing and stays set
        wr(ADDR_CH_SEL, 8'h00);
        wr(ADDR_CTL_B, 8'h01);
        quiet(20);
        rd(ADDR_CTL_B, 1'b0, 16'h0001, "run without channel");
        report_and_stop();
    end
endmodule : sar_adc_register_interface_tb_top
